// File: design/bbc_bus_if.sv
// Register access path between the host and the configuration registers.
// Assumes both ends run on the same clock; one request per transfer.
`timescale 1ns/1ps
`default_nettype none
interface bbc_bus_if;
    import bbc_pkg::*;
    logic req_wr;
    logic req_rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic ack;
    logic [DATA_W-1:0] rdata;

    modport dev
    (
        input req_wr,
        input req_rd,
        input addr,
        input wdata,
        output ack,
        output rdata
    );

    modport host
    (
        output req_wr,
        output req_rd,
        output addr,
        output wdata,
        input ack,
        input rdata
    );
endinterface
`default_nettype wire

// File: design/bbc_config_host.sv
// Host end: turns user requests into single register transfers.
// Assumes the register end answers every request with one ack pulse.
`timescale 1ns/1ps
`default_nettype none
module bbc_config_host
    import bbc_pkg::*;
#(
    parameter logic [7:0] OTP_TOP = OTP_TOP_DEFAULT
)
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic START,
    input wire logic WRITE,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] WDATA,
    output logic BUSY,
    output logic DONE,
    output logic [DATA_W-1:0] RDATA,
    bbc_bus_if.host BUS
);

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'h1,
        ST_ISSUE = 3'h2,
        ST_WAIT = 3'h4
    } bbc_state_t;

    bbc_state_t state;
    bbc_state_t next_state;
    logic req_wr;
    logic req_rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic busy;
    logic done;
    logic [7:0] rdata;
    logic next_req_wr;
    logic next_req_rd;
    logic [7:0] next_addr;
    logic [7:0] next_wdata;
    logic next_busy;
    logic next_done;
    logic [7:0] next_rdata;
    logic req_wr_last;
    logic next_req_wr_last;

    always_comb
    begin
        next_state = state;
        next_req_wr = 1'b0;
        next_req_rd = 1'b0;
        next_addr = addr;
        next_wdata = wdata;
        next_busy = busy;
        next_done = 1'b0;
        next_rdata = rdata;
        unique case (state)
            ST_IDLE:
            begin
                if (START)
                begin
                    next_state = ST_ISSUE;
                    next_req_wr = WRITE;
                    next_req_rd = ~WRITE;
                    next_addr = ADDR;
                    next_wdata = WDATA;
                    next_busy = 1'b1;
                    if (WRITE && ADDR == TOP_CONFIG_OFFSET)
                    begin
                        // Zero the spare and reserved bits, keep defaults
                        next_wdata = (WDATA & ~(TOP_ZERO_MASK | TOP_KEEP_MASK))
                            | (OTP_TOP & TOP_KEEP_MASK);
                    end
                end
            end
            ST_ISSUE:
            begin
                next_state = ST_WAIT;
            end
            ST_WAIT:
            begin
                if (BUS.ack)
                begin
                    next_state = ST_IDLE;
                    next_busy = 1'b0;
                    next_done = 1'b1;
                    if (!req_wr_last)
                    begin
                        next_rdata = BUS.rdata;
                    end
                end
            end
        endcase
    end

    always_comb
    begin
        next_req_wr_last = (state == ST_IDLE && START) ? WRITE : req_wr_last;
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            state <= ST_IDLE;
            req_wr <= 1'b0;
            req_rd <= 1'b0;
            addr <= 8'h00;
            wdata <= 8'h00;
            busy <= 1'b0;
            done <= 1'b0;
            rdata <= 8'h00;
            req_wr_last <= 1'b0;
        end
        else
        begin
            state <= next_state;
            req_wr <= next_req_wr;
            req_rd <= next_req_rd;
            addr <= next_addr;
            wdata <= next_wdata;
            busy <= next_busy;
            done <= next_done;
            rdata <= next_rdata;
            req_wr_last <= next_req_wr_last;
        end
    end

    assign BUS.req_wr = req_wr;
    assign BUS.req_rd = req_rd;
    assign BUS.addr = addr;
    assign BUS.wdata = wdata;
    assign BUSY = busy;
    assign DONE = done;
    assign RDATA = rdata;

endmodule
`default_nettype wire

// File: design/bbc_config_regs.sv
// Converter configuration registers: top config and channel 0 config.
// Assumes the host holds a request for one cycle and waits for ack.
//
// Function
// - Reset hold time follows programmed default only
// - Bias default bit sets bias select reset
// - Writing bias default leaves bias mode alone
// - Debounce default bit sets debounce select reset
// - Writing debounce default leaves debounce alone
// - Software keeps default bits at programmed values
// - Software writes bit seven as zero
// - Software writes reserved bits three, two zero
// - Drive code picks transition speed, higher slower
// - Drive strength applies to all channels
// - Voltage code maps linearly, 25 mV steps
`timescale 1ns/1ps
`default_nettype none
module bbc_config_regs
    import bbc_pkg::*;
#(
    parameter logic [7:0] OTP_TOP = OTP_TOP_DEFAULT,
    parameter logic [7:0] OTP_CH0 = OTP_CH0_DEFAULT,
    parameter int CHANNELS = NUM_CHANNELS,
    parameter logic [11:0] PEAK_CODE0_MA = 12'h3e8,
    parameter logic [11:0] PEAK_CODE1_MA = 12'h352
)
(
    input wire logic CLK,
    input wire logic SYS_RST,
    bbc_bus_if.dev BUS,
    output logic [4:0] MANUAL_RESET_HOLD_TIME_S,
    output logic BIAS_LOWPOWER_SELECT_RESET,
    output logic [14:0] ENABLE_PIN_DEBOUNCE_US,
    output logic ENABLE_PIN_DEBOUNCE_SELECT_RESET,
    output logic [2*CHANNELS-1:0] CONVERTER_DRIVE_STRENGTH,
    output logic [1:0] CHANNEL0_PEAK_CURRENT_LIMIT,
    output logic [11:0] CHANNEL0_PEAK_CURRENT_MA,
    output logic [5:0] CHANNEL0_TARGET_VOLTAGE,
    output logic [11:0] CHANNEL0_TARGET_MV
);

    function automatic logic [11:0] peak_ma(input logic [1:0] code);
        logic [11:0] ma;
        ma = PEAK_CODE0_MA;
        unique case (code)
            2'h0: ma = PEAK_CODE0_MA;
            2'h1: ma = PEAK_CODE1_MA;
            2'h2: ma = PEAK_CODE2_MA;
            2'h3: ma = PEAK_CODE3_MA;
        endcase
        return ma;
    endfunction

    function automatic logic [11:0] volt_mv(input logic [5:0] code);
        logic [11:0] mv;
        mv = VOLT_BASE_MV + VOLT_STEP_MV * {6'h00, code};
        return mv;
    endfunction

    logic [7:0] top_reg;
    logic [7:0] ch0_reg;
    logic ack;
    logic [7:0] rdata;
    logic [4:0] mrst_s;
    logic bias_rst;
    logic dbnc_rst;
    logic [14:0] dbnc_us;
    logic [2*CHANNELS-1:0] drive;
    logic [1:0] peak;
    logic [11:0] peak_ma_val;
    logic [5:0] volt;
    logic [11:0] volt_mv_val;

    logic [7:0] next_top_reg;
    logic [7:0] next_ch0_reg;
    logic next_ack;
    logic [7:0] next_rdata;
    logic [4:0] next_mrst_s;
    logic next_bias_rst;
    logic next_dbnc_rst;
    logic [14:0] next_dbnc_us;
    logic [2*CHANNELS-1:0] next_drive;
    logic [1:0] next_peak;
    logic [11:0] next_peak_ma_val;
    logic [5:0] next_volt;
    logic [11:0] next_volt_mv_val;

    // Register storage and bus answers
    always_comb
    begin
        next_top_reg = top_reg;
        next_ch0_reg = ch0_reg;
        next_ack = BUS.req_wr | BUS.req_rd;
        next_rdata = UNMAPPED_READ;
        if (BUS.req_wr)
        begin
            // Default bits are stored only; they steer nothing after reset
            if (BUS.addr == TOP_CONFIG_OFFSET)
            begin
                next_top_reg = BUS.wdata;
            end
            if (BUS.addr == CH0_CONFIG_OFFSET)
            begin
                next_ch0_reg = BUS.wdata;
            end
        end
        if (BUS.req_rd)
        begin
            if (BUS.addr == TOP_CONFIG_OFFSET)
            begin
                next_rdata = top_reg;
            end
            else if (BUS.addr == CH0_CONFIG_OFFSET)
            begin
                next_rdata = ch0_reg;
            end
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            top_reg <= OTP_TOP;
            ch0_reg <= OTP_CH0;
            ack <= 1'b0;
            rdata <= UNMAPPED_READ;
        end
        else
        begin
            top_reg <= next_top_reg;
            ch0_reg <= next_ch0_reg;
            ack <= next_ack;
            rdata <= next_rdata;
        end
    end

    assign BUS.ack = ack;
    assign BUS.rdata = rdata;

    // Fixed settings taken from the programmed defaults only
    always_comb
    begin
        next_mrst_s = OTP_TOP[TOP_MRST_BIT] ? MRST_SHORT_S : MRST_LONG_S;
        next_bias_rst = OTP_TOP[TOP_BIAS_DEF_BIT];
        next_dbnc_rst = OTP_TOP[TOP_DBNC_DEF_BIT];
        next_dbnc_us = OTP_TOP[TOP_DBNC_DEF_BIT] ? DBNC_LONG_US : DBNC_SHORT_US;
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            mrst_s <= MRST_LONG_S;
            bias_rst <= 1'b0;
            dbnc_rst <= 1'b0;
            dbnc_us <= DBNC_SHORT_US;
        end
        else
        begin
            mrst_s <= next_mrst_s;
            bias_rst <= next_bias_rst;
            dbnc_rst <= next_dbnc_rst;
            dbnc_us <= next_dbnc_us;
        end
    end

    // Drive strength fanned out to every channel
    generate
        for (genvar ch = 0; ch < CHANNELS; ch++)
        begin : g_drive
            assign next_drive[2*ch+1:2*ch] = top_reg[TOP_DRV_HI:TOP_DRV_LO];
        end
    endgenerate

    // Channel 0 limit and voltage decode
    always_comb
    begin
        next_peak = ch0_reg[CH0_PEAK_HI:CH0_PEAK_LO];
        next_peak_ma_val = peak_ma(ch0_reg[CH0_PEAK_HI:CH0_PEAK_LO]);
        next_volt = ch0_reg[CH0_VOLT_HI:CH0_VOLT_LO];
        next_volt_mv_val = volt_mv(ch0_reg[CH0_VOLT_HI:CH0_VOLT_LO]);
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            drive <= '0;
            peak <= 2'h0;
            peak_ma_val <= PEAK_CODE0_MA;
            volt <= 6'h00;
            volt_mv_val <= VOLT_BASE_MV;
        end
        else
        begin
            drive <= next_drive;
            peak <= next_peak;
            peak_ma_val <= next_peak_ma_val;
            volt <= next_volt;
            volt_mv_val <= next_volt_mv_val;
        end
    end

    assign MANUAL_RESET_HOLD_TIME_S = mrst_s;
    assign BIAS_LOWPOWER_SELECT_RESET = bias_rst;
    assign ENABLE_PIN_DEBOUNCE_US = dbnc_us;
    assign ENABLE_PIN_DEBOUNCE_SELECT_RESET = dbnc_rst;
    assign CONVERTER_DRIVE_STRENGTH = drive;
    assign CHANNEL0_PEAK_CURRENT_LIMIT = peak;
    assign CHANNEL0_PEAK_CURRENT_MA = peak_ma_val;
    assign CHANNEL0_TARGET_VOLTAGE = volt;
    assign CHANNEL0_TARGET_MV = volt_mv_val;

endmodule
`default_nettype wire

// File: design/bbc_pkg.sv
// Package for the converter configuration registers and their host.
// Assumes a single 100 MHz clock domain shared by both ends.
package bbc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    localparam logic [7:0] TOP_CONFIG_OFFSET = 8'h28;
    localparam logic [7:0] CH0_CONFIG_OFFSET = 8'h29;

    // Top configuration field positions
    localparam int TOP_SPARE_BIT = 7;
    localparam int TOP_MRST_BIT = 6;
    localparam int TOP_BIAS_DEF_BIT = 5;
    localparam int TOP_DBNC_DEF_BIT = 4;
    localparam int TOP_RSVD_HI = 3;
    localparam int TOP_RSVD_LO = 2;
    localparam int TOP_DRV_HI = 1;
    localparam int TOP_DRV_LO = 0;

    // Channel 0 configuration field positions
    localparam int CH0_PEAK_HI = 7;
    localparam int CH0_PEAK_LO = 6;
    localparam int CH0_VOLT_HI = 5;
    localparam int CH0_VOLT_LO = 0;

    // Bits that software must keep at zero when writing the top register
    localparam logic [7:0] TOP_ZERO_MASK = 8'h8c;
    // Bits that software keeps at their programmed default
    localparam logic [7:0] TOP_KEEP_MASK = 8'h70;

    // Programmed defaults (neutral values)
    localparam logic [7:0] OTP_TOP_DEFAULT = 8'h01;
    localparam logic [7:0] OTP_CH0_DEFAULT = 8'h00;

    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Manual reset hold times in seconds
    localparam logic [4:0] MRST_LONG_S = 5'h10;
    localparam logic [4:0] MRST_SHORT_S = 5'h08;

    // Enable pin debounce times in microseconds
    localparam logic [14:0] DBNC_SHORT_US = 15'h0064;
    localparam logic [14:0] DBNC_LONG_US = 15'h7530;

    // Target voltage transfer function in millivolts
    localparam logic [11:0] VOLT_BASE_MV = 12'h320;
    localparam logic [11:0] VOLT_STEP_MV = 12'h019;

    // Peak current limits in milliamps for the two codes with printed values
    localparam logic [11:0] PEAK_CODE2_MA = 12'h2c3;
    localparam logic [11:0] PEAK_CODE3_MA = 12'h1f4;

    // Number of converter output channels sharing the drive strength
    localparam int NUM_CHANNELS = 3;
endpackage

// File: tb/bbc_properties.sv
// Bus checker for the configuration registers and their host end.
// Assumes it is placed beside the shared bus interface, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module bbc_properties
    import bbc_pkg::*;
#(
    parameter logic [7:0] OTP_TOP = OTP_TOP_DEFAULT,
    parameter logic [7:0] OTP_CH0 = OTP_CH0_DEFAULT
)
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic req_wr,
    input wire logic req_rd,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic ack,
    input wire logic [DATA_W-1:0] rdata
);
    logic [7:0] top;
    logic [7:0] ch0;
    logic req;
    logic top_hit;
    assign req = req_wr || req_rd;
    assign top_hit = addr == TOP_CONFIG_OFFSET;
    // Copies of both registers rebuilt from bus writes
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            top <= OTP_TOP;
            ch0 <= OTP_CH0;
        end
        else if (req_wr && top_hit)
            top <= wdata;
        else if (req_wr && addr == CH0_CONFIG_OFFSET)
            ch0 <= wdata;
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    ack_after_req_a: assert property (req |=> ack)
        else $error("request not answered next cycle");
    ack_has_cause_a: assert property (ack |-> $past(req))
        else $error("answer without request");
    host_spacing_a: assert property (req |=> !req [*2])
        else $error("requests too close");
    top_readback_a: assert property (req_rd && top_hit |=> rdata == top)
        else $error("top register read wrong");
    ch0_readback_a: assert property (req_rd && addr == CH0_CONFIG_OFFSET |=> rdata == ch0)
        else $error("channel register read wrong");
    unmapped_read_a: assert property (req_rd && !top_hit && addr != CH0_CONFIG_OFFSET
        |=> rdata == UNMAPPED_READ)
        else $error("unmapped read not zero");
    write_data_zero_a: assert property (ack && $past(req_wr) |-> rdata == 8'h00)
        else $error("write answer carries data");
    zero_bits_a: assert property (req_wr && top_hit |-> (wdata & TOP_ZERO_MASK) == 8'h00)
        else $error("reserved bits written nonzero");
    keep_bits_a: assert property (req_wr && top_hit
        |-> (wdata & TOP_KEEP_MASK) == (OTP_TOP & TOP_KEEP_MASK))
        else $error("default bits not kept");
endmodule
`default_nettype wire

// File: tb/buck_boost_config_regs_test.sv
// Self-checking bench: host end drives the register end over the bus.
// Assumes one 100 MHz clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module buck_boost_config_regs_test;
    import bbc_pkg::*;
    localparam logic [7:0] TOPD = 8'h51;
    localparam logic [7:0] CH0D = 8'h8a;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic start = 1'b0;
    logic write = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic busy, done, bias_rst, dbnc_rst;
    logic [7:0] rdata;
    logic [7:0] rd;
    logic [4:0] hold_s;
    logic [14:0] dbnc_us;
    logic [5:0] drv;
    logic [5:0] volt;
    logic [1:0] peak;
    logic [11:0] peak_ma, volt_mv;
    int mismatches = 0;
    int n_tests = 0;
    int cycles = 0;
    bbc_bus_if bus();
    bbc_config_regs #(.OTP_TOP(TOPD), .OTP_CH0(CH0D)) i_bbc_config_regs
    (
        .CLK(clk), .SYS_RST(sys_rst), .BUS(bus.dev), .MANUAL_RESET_HOLD_TIME_S(hold_s),
        .BIAS_LOWPOWER_SELECT_RESET(bias_rst), .ENABLE_PIN_DEBOUNCE_US(dbnc_us),
        .ENABLE_PIN_DEBOUNCE_SELECT_RESET(dbnc_rst), .CONVERTER_DRIVE_STRENGTH(drv),
        .CHANNEL0_PEAK_CURRENT_LIMIT(peak), .CHANNEL0_PEAK_CURRENT_MA(peak_ma),
        .CHANNEL0_TARGET_VOLTAGE(volt), .CHANNEL0_TARGET_MV(volt_mv)
    );
    bbc_config_host #(.OTP_TOP(TOPD)) i_bbc_config_host
    (
        .CLK(clk), .SYS_RST(sys_rst), .START(start), .WRITE(write), .ADDR(addr),
        .WDATA(wdata), .BUSY(busy), .DONE(done), .RDATA(rdata), .BUS(bus.host)
    );
    bbc_properties #(.OTP_TOP(TOPD), .OTP_CH0(CH0D)) i_bbc_properties
    (
        .CLK(clk), .SYS_RST(sys_rst), .req_wr(bus.req_wr), .req_rd(bus.req_rd),
        .addr(bus.addr), .wdata(bus.wdata), .ack(bus.ack), .rdata(bus.rdata)
    );
    initial
    begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            results();
        end
    end
    function automatic logic [11:0] exp_ma(input logic [1:0] c);
        case (c)
            2'h0: return 12'h3e8;
            2'h1: return 12'h352;
            2'h2: return 12'h2c3;
            default: return 12'h1f4;
        endcase
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // One host transfer; ends just after the done edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        @(posedge clk);
        start <= 1'b1;
        write <= w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        start <= 1'b0;
        k = 0;
        do
        begin
            @(posedge clk);
            #1;
            k++;
            if (k == 1)
            begin
                chk(16'(busy), 16'h0001);
            end
        end
        while (done !== 1'b1 && k < 10);
        chk(16'(done), 16'h0001);
        chk(16'(busy), 16'h0000);
        rd = rdata;
    endtask
    task automatic check_out(input logic [7:0] t, input logic [7:0] c);
        chk(16'(hold_s), TOPD[6] ? 16'h0008 : 16'h0010);
        chk(16'(bias_rst), 16'(TOPD[5]));
        chk(16'(dbnc_rst), 16'(TOPD[4]));
        chk(16'(dbnc_us), TOPD[4] ? 16'h7530 : 16'h0064);
        chk(16'(drv), 16'({3{t[1:0]}}));
        chk(16'(peak), 16'(c[7:6]));
        chk(16'(peak_ma), 16'(exp_ma(c[7:6])));
        chk(16'(volt), 16'(c[5:0]));
        chk(16'(volt_mv), 16'h0320 + 16'h0019 * 16'(c[5:0]));
        xfer(1'b0, TOP_CONFIG_OFFSET, 8'h00);
        chk(16'(rd), 16'(t));
        xfer(1'b0, CH0_CONFIG_OFFSET, 8'h00);
        chk(16'(rd), 16'(c));
    endtask
    initial
    begin
        logic [7:0] d;
        logic [7:0] t;
        void'($urandom(32'h7bb63092));
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check_out(TOPD, CH0D);
        $display("test reset_defaults done");
        // Corner codes first, then random words
        for (int i = 0; i < 24; i++)
        begin
            d = (i < 4) ? (8'hfc | 8'(i)) : 8'($urandom);
            xfer(1'b1, TOP_CONFIG_OFFSET, d);
            t = (d & 8'h03) | (TOPD & TOP_KEEP_MASK);
            d = (i < 4) ? 8'(8'h55 * i) : 8'($urandom);
            xfer(1'b1, CH0_CONFIG_OFFSET, d);
            check_out(t, d);
        end
        $display("test field_writes done");
        xfer(1'b1, 8'h2a, 8'hff);
        xfer(1'b0, 8'h2a, 8'h00);
        chk(16'(rd), 16'(UNMAPPED_READ));
        check_out(t, d);
        $display("test unmapped done");
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check_out(TOPD, CH0D);
        $display("test second_reset done");
        results();
    end
endmodule
`default_nettype wire
